/* File: hw/tcb_ctrl_top.v */
// timer/counter with set/clear control-B register pair behind an apb slave
`timescale 1ns/1ns
`default_nettype none
`include "tcb_regs.vh"
module tcb_ctrl_top #(
  parameter CW = 16,
  parameter DW = 8
) (
  input  wire          clock,
  input  wire          rst_n,
  input  wire [11:0]   paddr,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [31:0]   pwdata,
  input  wire [3:0]    pstrb,
  output wire [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  input  wire          writeProtect,
  output reg  [CW-1:0] countValue,
  output reg           countDown,
  output reg           countRunning,
  output reg           updatePulse
);

  // register select codes
  localparam [2:0] SEL_NONE = 3'h7;
  localparam [CW-1:0] ONE   = {{(CW-1){1'b0}}, 1'b1};

  // decode a byte address into a register index, or none
  function [2:0] regSel;
    input [11:0] addr;
    begin
      if (addr[11:5] != 7'h00 || addr[1:0] != 2'b00) begin
        regSel = SEL_NONE;
      end else if (addr[4:2] > `TCB_IDX_CTRLB_SET) begin
        regSel = SEL_NONE;
      end else begin
        regSel = addr[4:2];
      end
    end
  endfunction

  // software visible state
  reg          enable_r;    // counter enable
  reg [DW-1:0] div_r;       // prescaler divide value
  reg          dirDown_r;   // count direction, 1 is down
  reg          lockUpd_r;   // buffer update lock
  reg          single_r;    // single shot mode
  reg [1:0]    rampIdx_r;   // ramp index command, stored only
  reg [2:0]    cmd_r;       // posted command, zero when idle
  reg [2:0]    cmd_nxt;     // next posted command
  reg [CW-1:0] perBuf_r;    // buffered period
  reg [CW-1:0] perAct_r;    // active period
  reg [CW-1:0] count_r;     // counter value
  reg          running_r;   // counter is running
  reg [31:0]   prdata_r;    // read data latched in setup phase
  reg [31:0]   rdMux;       // combinational read mux

  wire       tick;          // prescaled counter clock enable
  wire [2:0] sel;           // decoded register
  wire       setupPh;       // apb setup phase
  wire       accessPh;      // apb access phase
  wire       ctrlBHit;      // either control-B view addressed
  wire       errResp;       // slave error for this access
  wire       wrEn;          // write takes effect this cycle
  wire [7:0] ctrlB;         // shared control-B image
  wire [2:0] wrCmd;         // command field of write data
  wire       cmdValid;      // write carries a valid command
  wire       postCmd;       // a command is posted this cycle
  wire       atEnd;         // counter at end of its range
  wire       stepEn;        // counter advances this cycle

  assign sel      = regSel(paddr);
  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  assign ctrlBHit = (sel == `TCB_IDX_CTRLB_SET) | (sel == `TCB_IDX_CTRLB_CLR);
  assign errResp  = accessPh & ((sel == SEL_NONE) | (pwrite & ctrlBHit & writeProtect));
  assign wrEn     = accessPh & pwrite & ~errResp;
  assign pready   = 1'b1;
  assign pslverr  = errResp;
  assign prdata   = prdata_r;

  assign ctrlB = {cmd_r, rampIdx_r, single_r, lockUpd_r, dirDown_r};

  assign wrCmd    = pwdata[`TCB_B_CMD_HI:`TCB_B_CMD_LO];
  assign cmdValid = (wrCmd == `TCB_CMD_RETRIGGER) | (wrCmd == `TCB_CMD_STOP);
  assign postCmd  = wrEn & ctrlBHit & pstrb[0] & cmdValid;

  // prescaler feeding the counter clock enable
  tcb_prescaler #(
    .DW (DW)
  ) u_presc (
    .clock  (clock),
    .rst_n  (rst_n),
    .enable (enable_r),
    .divide (div_r),
    .tick   (tick)
  );

  // read mux over all registers
  always @* begin
    rdMux = 32'h0000_0000;
    case (sel)
      `TCB_IDX_CTRL: begin
        rdMux[`TCB_CTRL_EN] = enable_r;
        rdMux[`TCB_CTRL_DIV_HI:`TCB_CTRL_DIV_LO] = div_r;
      end
      `TCB_IDX_COUNT: begin
        rdMux[CW-1:0] = count_r;
      end
      `TCB_IDX_PER: begin
        rdMux[CW-1:0] = perAct_r;
      end
      `TCB_IDX_PERBUF: begin
        rdMux[CW-1:0] = perBuf_r;
      end
      `TCB_IDX_CTRLB_CLR: begin
        rdMux[7:0] = ctrlB;
      end
      `TCB_IDX_CTRLB_SET: begin
        rdMux[7:0] = ctrlB;
      end
      default: begin
        rdMux = 32'h0000_0000;
      end
    endcase
  end

  // read data captured in setup so it comes from a flop
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (setupPh & ~pwrite) begin
      prdata_r <= rdMux;
    end
  end

  // control register and period buffer writes
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= 1'b0;
      div_r    <= `TCB_DIV_RST;
      perBuf_r <= `TCB_PER_RST;
    end else if (wrEn) begin
      if (sel == `TCB_IDX_CTRL) begin
        // byte lanes honoured per field
        if (pstrb[0]) begin
          enable_r <= pwdata[`TCB_CTRL_EN];
        end
        if (pstrb[1]) begin
          div_r <= pwdata[`TCB_CTRL_DIV_HI:`TCB_CTRL_DIV_LO];
        end
      end else if (sel == `TCB_IDX_PERBUF) begin
        if (pstrb[0]) begin
          perBuf_r[7:0] <= pwdata[7:0];
        end
        if (pstrb[1]) begin
          perBuf_r[CW-1:8] <= pwdata[CW-1:8];
        end
      end
    end
  end

  // control-B bits through the set and clear views
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dirDown_r <= 1'b0;
      lockUpd_r <= 1'b0;
      single_r  <= 1'b0;
      rampIdx_r <= 2'b00;
    end else if (wrEn & pstrb[0]) begin
      if (sel == `TCB_IDX_CTRLB_SET) begin
        dirDown_r <= dirDown_r | pwdata[`TCB_B_DIR];
        lockUpd_r <= lockUpd_r | pwdata[`TCB_B_LOCK];
        single_r  <= single_r  | pwdata[`TCB_B_SINGLE];
        rampIdx_r <= rampIdx_r | pwdata[`TCB_B_IDX_HI:`TCB_B_IDX_LO];
      end else if (sel == `TCB_IDX_CTRLB_CLR) begin
        dirDown_r <= dirDown_r & ~pwdata[`TCB_B_DIR];
        lockUpd_r <= lockUpd_r & ~pwdata[`TCB_B_LOCK];
        single_r  <= single_r  & ~pwdata[`TCB_B_SINGLE];
        rampIdx_r <= rampIdx_r & ~pwdata[`TCB_B_IDX_HI:`TCB_B_IDX_LO];
      end
    end
  end

  // posted command: new post wins over the clear on execution
  always @* begin
    cmd_nxt = cmd_r;
    if (postCmd) begin
      cmd_nxt = wrCmd;
    end else if (tick) begin
      cmd_nxt = `TCB_CMD_NONE;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r <= `TCB_CMD_NONE;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  // end of range depends on direction
  assign atEnd  = dirDown_r ? (count_r == {CW{1'b0}}) : (count_r == perAct_r);
  assign stepEn = tick & running_r & (cmd_r == `TCB_CMD_NONE);

  // counter, run state and period update
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r     <= {CW{1'b0}};
      running_r   <= 1'b0;
      perAct_r    <= `TCB_PER_RST;
      updatePulse <= 1'b0;
    end else begin
      updatePulse <= 1'b0;
      if (wrEn & (sel == `TCB_IDX_CTRL) & pstrb[0] & pwdata[`TCB_CTRL_EN] & ~enable_r) begin
        // enabling starts the count
        running_r <= 1'b1;
      end else if (tick & (cmd_r == `TCB_CMD_RETRIGGER)) begin
        running_r <= 1'b1;
        count_r   <= dirDown_r ? perAct_r : {CW{1'b0}};
      end else if (tick & (cmd_r == `TCB_CMD_STOP)) begin
        running_r <= 1'b0;
      end else if (stepEn) begin
        if (atEnd) begin
          // wrap is the hardware update condition
          updatePulse <= 1'b1;
          if (!lockUpd_r) begin
            perAct_r <= perBuf_r;
          end
          count_r <= dirDown_r ? (lockUpd_r ? perAct_r : perBuf_r) : {CW{1'b0}};
          if (single_r) begin
            running_r <= 1'b0;
          end
        end else begin
          count_r <= dirDown_r ? (count_r - ONE) : (count_r + ONE);
        end
      end
    end
  end

  // registered status outputs
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      countValue   <= {CW{1'b0}};
      countDown    <= 1'b0;
      countRunning <= 1'b0;
    end else begin
      countValue   <= count_r;
      countDown    <= dirDown_r;
      countRunning <= running_r;
    end
  end

endmodule
`default_nettype wire

/* File: pkg/tcb_regs.vh */
// register map, field positions and reset values of the counter control block
`ifndef TCB_REGS_VH
`define TCB_REGS_VH

// register indices; byte address is four times the index
`define TCB_IDX_CTRL      3'h0
`define TCB_IDX_COUNT     3'h1
`define TCB_IDX_PER       3'h2
`define TCB_IDX_PERBUF    3'h3
`define TCB_IDX_CTRLB_CLR 3'h4
`define TCB_IDX_CTRLB_SET 3'h5

// control register fields
`define TCB_CTRL_EN       0
`define TCB_CTRL_DIV_LO   8
`define TCB_CTRL_DIV_HI   15

// control-B fields
`define TCB_B_DIR         0
`define TCB_B_LOCK        1
`define TCB_B_SINGLE      2
`define TCB_B_IDX_LO      3
`define TCB_B_IDX_HI      4
`define TCB_B_CMD_LO      5
`define TCB_B_CMD_HI      7

// command codes
`define TCB_CMD_NONE      3'h0
`define TCB_CMD_RETRIGGER 3'h1
`define TCB_CMD_STOP      3'h2

// reset values
`define TCB_CTRLB_RST     8'h00
`define TCB_DIV_RST       8'h00
`define TCB_PER_RST       16'hFFFF

`endif

/* File: hw/tcb_prescaler.v */
// prescaler that turns the bus clock into one-cycle counter clock enables
`timescale 1ns/1ns
`default_nettype none
module tcb_prescaler #(
  parameter DW = 8
) (
  input  wire          clock,
  input  wire          rst_n,
  input  wire          enable,
  input  wire [DW-1:0] divide,
  output reg           tick
);

  reg  [DW-1:0] cnt_r;   // cycles since last tick
  wire [DW-1:0] cnt_nxt; // incremented count

  assign cnt_nxt = cnt_r + {{(DW-1){1'b0}}, 1'b1};

  // one tick every divide+1 clocks while enabled
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {DW{1'b0}};
      tick  <= 1'b0;
    end else if (!enable) begin
      // idle: restart the division cleanly
      cnt_r <= {DW{1'b0}};
      tick  <= 1'b0;
    end else if (cnt_r >= divide) begin
      // at or past the limit: a smaller divide written mid-count must not wrap the counter
      cnt_r <= {DW{1'b0}};
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: verification/tcb_ctrl_monitor.sv */
// port checker for the counter control block
`timescale 1ns/1ns
`default_nettype none
module tcb_ctrl_monitor #(
  parameter CW = 16
) (
  input wire logic          clock,
  input wire logic          rst_n,
  input wire logic [11:0]   paddr,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [31:0]   pwdata,
  input wire logic [3:0]    pstrb,
  input wire logic [31:0]   prdata,
  input wire logic          pslverr,
  input wire logic          writeProtect,
  input wire logic [CW-1:0] countValue,
  input wire logic          countDown,
  input wire logic          countRunning
);
  // access cycle and control-B view decode
  wire logic acc = psel & penable;
  wire logic isB = (paddr == 12'h010) | (paddr == 12'h014);
  wire logic bWr = acc & pwrite & ~writeProtect & isB & pstrb[0];
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  b_read_width_a: assert property (acc && !pwrite && isB |-> prdata[31:8] == 24'h0)
    else $error("control-B read has upper bits set");
  protect_err_a: assert property (acc && pwrite && writeProtect && isB |-> pslverr)
    else $error("protected write not refused");
  err_access_a: assert property (pslverr |-> acc)
    else $error("error flag outside access cycle");
  unaligned_err_a: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unaligned access not refused");
  dir_set_a: assert property (bWr && paddr == 12'h014 && pwdata[0] |-> ##2 countDown)
    else $error("set view did not set direction");
  dir_clr_a: assert property (bWr && paddr == 12'h010 && pwdata[0] |-> ##2 !countDown)
    else $error("clear view did not clear direction");
  dir_cause_a: assert property ($changed(countDown) |-> $past(bWr, 2))
    else $error("direction changed without a write");
  stop_hold_a: assert property (!countRunning && !$past(countRunning) |-> $stable(countValue))
    else $error("count moved while stopped");
endmodule
bind tcb_ctrl_top tcb_ctrl_monitor #(.CW(CW)) mon (.clock, .rst_n, .paddr, .psel, .penable,
  .pwrite, .pwdata, .pstrb, .prdata, .pslverr, .writeProtect,
  .countValue, .countDown, .countRunning);
`default_nettype wire

/* File: verification/tcb_ctrl_top_tb.sv */
// self-checking bench for the counter control block
`timescale 1ns/1ns
`default_nettype none
`include "tcb_regs.vh"
module tcb_ctrl_top_tb;
  localparam logic [11:0] A_CTL = 12'h000, A_CNT = 12'h004, A_PER = 12'h008;
  localparam logic [11:0] A_BUF = 12'h00C, A_CLR = 12'h010, A_SET = 12'h014;
  logic        clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, writeProtect = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, countDown, countRunning, updatePulse, er;
  logic [15:0] countValue, c0;
  int          err_count = 0, checks_done = 0;
  // free running bus clock
  always #10 clock = ~clock;
  tcb_ctrl_top dut (.clock, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .writeProtect, .countValue, .countDown, .countRunning,
    .updatePulse);
  // compare and count
  task chk(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, access until pready, release
  task xfer(input [11:0] a, input w, input [31:0] d, input e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    chk(pready, 1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    chk(er, e);
  endtask
  task wr(input [11:0] a, input [31:0] d, input e);
    xfer(a, 1'b1, d, e);
  endtask
  task rdc(input [11:0] a, input [31:0] exp, input e);
    xfer(a, 1'b0, 32'h0, e);
    chk(rd, exp);
  endtask
  // wait for the next wrap pulse, bounded
  task waitUpd;
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (updatePulse !== 1'b1 && n < 70000);
    chk(n < 70000, 1);
  endtask
  task close_out;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // cut a hang short
  initial begin
    repeat (80000) @(posedge clock);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out;
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdc(A_SET, {24'h0, `TCB_CTRLB_RST}, 0);
    rdc(A_CLR, 32'h0, 0);
    $display("reset values done");
    wr(A_SET, 32'h07, 0);
    rdc(A_CLR, 32'h07, 0);
    chk(countDown, 1);
    wr(A_SET, 32'h00, 0);
    wr(A_CLR, 32'h00, 0);
    rdc(A_SET, 32'h07, 0);
    wr(A_CLR, 32'h01, 0);
    rdc(A_SET, 32'h06, 0);
    chk(countDown, 0);
    writeProtect <= 1'b1;
    wr(A_SET, 32'h01, 1);
    wr(A_CLR, 32'h06, 1);
    writeProtect <= 1'b0;
    rdc(A_SET, 32'h06, 0);
    wr(A_CLR, 32'h06, 0);
    rdc(12'h018, 32'h0, 1);
    rdc(12'h015, 32'h0, 1);
    $display("set and clear views done");
    // enable, tick every fourth clock
    wr(A_CTL, 32'h0301, 0);
    xfer(A_CNT, 1'b0, 32'h0, 0);
    c0 = rd[15:0];
    repeat (8) @(posedge clock);
    xfer(A_CNT, 1'b0, 32'h0, 0);
    chk(rd[15:0] > c0, 1);
    wr(A_SET, {24'h0, `TCB_CMD_STOP, 5'h00}, 0);
    repeat (5) @(posedge clock);
    chk(countRunning, 0);
    rdc(A_SET, 32'h00, 0);
    c0 = countValue;
    repeat (8) @(posedge clock);
    chk(countValue, c0);
    for (int c = 3; c < 8; c++) begin
      wr(A_SET, c << 5, 0);
      rdc(A_SET, 32'h00, 0);
      chk(countRunning, 0);
    end
    wr(A_SET, {24'h0, `TCB_CMD_RETRIGGER, 5'h01}, 0);
    repeat (5) @(posedge clock);
    chk(countRunning, 1);
    rdc(A_SET, 32'h01, 0);
    xfer(A_CNT, 1'b0, 32'h0, 0);
    chk(rd[15:0] > 16'hFFE0 && rd[15:0] < 16'hFFFF, 1);
    $display("commands done");
    // full speed, up, new period via buffer
    wr(A_CLR, 32'h01, 0);
    wr(A_CTL, 32'h0001, 0);
    wr(A_BUF, 32'h10, 0);
    wr(A_SET, 32'h20, 0);
    waitUpd;
    rdc(A_PER, 32'h10, 0);
    wr(A_SET, 32'h02, 0);
    wr(A_BUF, 32'h20, 0);
    waitUpd;
    rdc(A_PER, 32'h10, 0);
    wr(A_CLR, 32'h02, 0);
    waitUpd;
    rdc(A_PER, 32'h20, 0);
    $display("update lock done");
    close_out;
  end
endmodule
`default_nettype wire
